// ===== verilog/pbs_defines.svh
// Contract
// (RULE_01) latch bit drives pin level in output mode
// (RULE_02) direction bit: 0 input, 1 output, reset input
// (RULE_03) function bits 6..4 pick peripheral output
// (RULE_04) output type: 0 push-pull, 1 open-drain
// (RULE_05) readback zero only for push-pull outputs
// (RULE_06) at most two serial units active
// (RULE_07) pair field decodes active serial unit pair
// (RULE_08) group bit routes serial pins port2/port b
// (RULE_09) timer a0 input from port2 or port9
// (RULE_10) software changes selection only when stopped
// (RULE_11) software clears interrupt latch after change
// (RULE_12) shared interrupt latches follow the selection
// (RULE_13) port b pins carry serial signals
// (RULE_14) selected peripheral output replaces latch value
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

`define PBS_AW 12
`define PBS_ADDR_LATCH 12'h00b
`define PBS_ADDR_READBACK 12'h018
`define PBS_ADDR_DIR 12'hf25
`define PBS_ADDR_FSEL 12'hf3f
`define PBS_ADDR_OTYPE 12'hf4c
`define PBS_ADDR_SEL 12'hfcb

`define PBS_PIN_HI 7
`define PBS_PIN_LO 4
`define PBS_FSEL_HI 6
`define PBS_SEL_TSEL_HI 7
`define PBS_SEL_TSEL_LO 6
`define PBS_SEL_GROUP 4
`define PBS_SEL_PAIR_HI 1
`define PBS_SEL_PAIR_LO 0

`define PBS_RST_PORT 4'h0
`define PBS_RST_FSEL 3'h0
`define PBS_RST_SEL 5'h00
`define PBS_LOW_NIBBLE 4'h0
`define PBS_ZERO_BYTE 8'h00

`define PBS_PAIR_UART_TWI 2'h0
`define PBS_PAIR_UART_SIO 2'h1
`define PBS_PAIR_SIO_TWI 2'h2
`define PBS_PAIR_RESERVED 2'h3
`define PBS_TSEL_PORT2 2'h0
`define PBS_TSEL_PORT9 2'h1

`endif

// ===== verilog/pbs_pkg.sv
`include "pbs_defines.svh"
package pbs_pkg;
    typedef enum logic [1:0] {
        PBS_PAIR_UART_TWI = `PBS_PAIR_UART_TWI,
        PBS_PAIR_UART_SIO = `PBS_PAIR_UART_SIO,
        PBS_PAIR_SIO_TWI = `PBS_PAIR_SIO_TWI,
        PBS_PAIR_RESERVED = `PBS_PAIR_RESERVED
    } pbs_pair_t;

    typedef struct packed {
        logic [1:0] tsel;
        logic group;
        pbs_pair_t pair;
    } pbs_sel_t;

    typedef struct packed {
        logic uart;
        logic sio;
        logic twi;
    } pbs_units_t;

    typedef struct packed {
        logic sclk;
        logic sdo;
        logic utx;
    } pbs_periph_out_t;

    typedef struct packed {
        logic sdi;
        logic urx;
        logic timer_in;
    } pbs_periph_in_t;

    typedef struct packed {
        logic uart_rx;
        logic sio;
        logic twi;
    } pbs_irq_t;

    typedef struct packed {
        logic [3:0] latch;
        logic [3:0] dir;
        logic [3:0] otype;
        logic [2:0] fsel;
        pbs_sel_t sel;
        logic [7:0] rdata;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        pbs_units_t unit_en;
        pbs_periph_in_t periph_in;
        logic [1:0] shared_irq;
        logic [2:0] port2_out;
    } pbs_state_t;
endpackage

// ===== verilog/pbs_pin_cell.sv
`timescale 1ns/1ps
module pbs_pin_cell (
    input wire logic dir,
    input wire logic otype,
    input wire logic fsel,
    input wire logic latch,
    input wire logic alt,
    input wire logic alt_ok,
    input wire logic pin_in,
    output logic out,
    output logic oe,
    output logic rd
);
    logic val;
    always_comb begin
        // peripheral value only when its unit is routed here
        val = (fsel && alt_ok) ? alt : latch; // [RULE_14]
        oe = dir && (!otype || !val); // [RULE_01] [RULE_02] [RULE_04]
        out = otype ? 1'b0 : val; // [RULE_04]
        rd = (!dir || otype) ? pin_in : 1'b0; // [RULE_05]
    end
endmodule // pbs_pin_cell

// ===== verilog/pbs_serial_router.sv
`timescale 1ns/1ps
`include "pbs_defines.svh"
module pbs_serial_router (
    input wire pbs_pkg::pbs_sel_t sel,
    input wire pbs_pkg::pbs_periph_out_t periph_out,
    input wire pbs_pkg::pbs_irq_t irq,
    input wire logic pb_pin5_in,
    input wire logic port2_pin1_in,
    input wire logic port9_pin1_in,
    output pbs_pkg::pbs_units_t unit_en,
    output logic [3:0] pb_alt,
    output logic [3:0] pb_alt_ok,
    output pbs_pkg::pbs_periph_in_t periph_in,
    output logic [1:0] shared_irq,
    output logic [2:0] port2_out
);
    logic sio_pair;
    logic uart_on;
    logic rx_src;
    always_comb begin
        // reserved code enables nothing, so never three units
        unit_en.uart = (sel.pair == pbs_pkg::PBS_PAIR_UART_TWI) ||
                       (sel.pair == pbs_pkg::PBS_PAIR_UART_SIO); // [RULE_06] [RULE_07]
        unit_en.sio = (sel.pair == pbs_pkg::PBS_PAIR_UART_SIO) ||
                      (sel.pair == pbs_pkg::PBS_PAIR_SIO_TWI); // [RULE_07]
        unit_en.twi = (sel.pair == pbs_pkg::PBS_PAIR_UART_TWI) ||
                      (sel.pair == pbs_pkg::PBS_PAIR_SIO_TWI); // [RULE_07]
        sio_pair = (sel.pair == pbs_pkg::PBS_PAIR_SIO_TWI);
        uart_on = unit_en.uart;
        pb_alt[0] = sio_pair ? periph_out.sdo : periph_out.utx; // [RULE_13]
        pb_alt[1] = periph_out.utx; // [RULE_13]
        pb_alt[2] = periph_out.sclk; // [RULE_13]
        pb_alt[3] = 1'b0;
        pb_alt_ok[0] = sel.group && (uart_on || sio_pair); // [RULE_08]
        pb_alt_ok[1] = sel.group && uart_on; // [RULE_08]
        pb_alt_ok[2] = sel.group && sio_pair; // [RULE_08]
        pb_alt_ok[3] = 1'b0;
        port2_out[0] = !sel.group && (sio_pair ? periph_out.sdo : (uart_on && periph_out.utx)); // [RULE_08]
        port2_out[1] = 1'b0;
        port2_out[2] = !sel.group && sio_pair && periph_out.sclk; // [RULE_08]
        rx_src = sel.group ? pb_pin5_in : port2_pin1_in; // [RULE_08]
        // idle-high receive line keeps a disabled uart quiet
        periph_in.urx = uart_on ? rx_src : 1'b1;
        periph_in.sdi = sio_pair ? rx_src : 1'b0;
        if (sel.tsel == `PBS_TSEL_PORT2) begin
            periph_in.timer_in = port2_pin1_in; // [RULE_09]
        end else if (sel.tsel == `PBS_TSEL_PORT9) begin
            periph_in.timer_in = port9_pin1_in; // [RULE_09]
        end else begin
            periph_in.timer_in = 1'b0;
        end
        // latch source flips with the pair; software must clear after a change
        shared_irq[0] = sio_pair ? irq.sio : (uart_on && irq.uart_rx); // [RULE_12] [RULE_11]
        shared_irq[1] = (sel.pair == pbs_pkg::PBS_PAIR_UART_SIO) ? irq.sio : (unit_en.twi && irq.twi); // [RULE_12]
    end
endmodule // pbs_serial_router

// ===== verilog/pbs_port_b.sv
`timescale 1ns/1ps
`include "pbs_defines.svh"
module pbs_port_b (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [`PBS_AW-1:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [3:0] pb_pin_in,
    output logic [3:0] pb_pin_out,
    output logic [3:0] pb_pin_oe,
    input wire logic port2_pin1_in,
    input wire logic port9_pin1_in,
    output logic [2:0] port2_out,
    input wire pbs_pkg::pbs_periph_out_t periph_out,
    output pbs_pkg::pbs_periph_in_t periph_in,
    input wire pbs_pkg::pbs_irq_t irq,
    output logic [1:0] shared_irq,
    output pbs_pkg::pbs_units_t unit_en
);
    localparam pbs_pkg::pbs_state_t RST_STATE = '{
        latch: `PBS_RST_PORT,
        dir: `PBS_RST_PORT,
        otype: `PBS_RST_PORT,
        fsel: `PBS_RST_FSEL,
        sel: `PBS_RST_SEL,
        default: '0
    };

    pbs_pkg::pbs_state_t state;
    pbs_pkg::pbs_state_t next_state;
    logic [3:0] cell_out;
    logic [3:0] cell_oe;
    logic [3:0] cell_rd;
    logic [3:0] alt;
    logic [3:0] alt_ok;
    logic [3:0] fsel_pin;
    pbs_pkg::pbs_units_t rt_en;
    pbs_pkg::pbs_periph_in_t rt_in;
    logic [1:0] rt_irq;
    logic [2:0] rt_p2;

    assign fsel_pin = {1'b0, state.fsel};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            pbs_pin_cell u_cell (
                .dir(state.dir[gi]),
                .otype(state.otype[gi]),
                .fsel(fsel_pin[gi]),
                .latch(state.latch[gi]),
                .alt(alt[gi]),
                .alt_ok(alt_ok[gi]),
                .pin_in(pb_pin_in[gi]),
                .out(cell_out[gi]),
                .oe(cell_oe[gi]),
                .rd(cell_rd[gi])
            );
        end
    endgenerate

    pbs_serial_router u_router (
        .sel(state.sel),
        .periph_out(periph_out),
        .irq(irq),
        .pb_pin5_in(pb_pin_in[1]),
        .port2_pin1_in(port2_pin1_in),
        .port9_pin1_in(port9_pin1_in),
        .unit_en(rt_en),
        .pb_alt(alt),
        .pb_alt_ok(alt_ok),
        .periph_in(rt_in),
        .shared_irq(rt_irq),
        .port2_out(rt_p2)
    );

    always_comb begin
        next_state = state;
        next_state.rdata = `PBS_ZERO_BYTE;
        if (sfr_wr) begin
            if (sfr_addr == `PBS_ADDR_LATCH) begin
                next_state.latch = sfr_wdata[`PBS_PIN_HI:`PBS_PIN_LO]; // [RULE_01]
            end else if (sfr_addr == `PBS_ADDR_DIR) begin
                next_state.dir = sfr_wdata[`PBS_PIN_HI:`PBS_PIN_LO]; // [RULE_02]
            end else if (sfr_addr == `PBS_ADDR_FSEL) begin
                next_state.fsel = sfr_wdata[`PBS_FSEL_HI:`PBS_PIN_LO]; // [RULE_03]
            end else if (sfr_addr == `PBS_ADDR_OTYPE) begin
                next_state.otype = sfr_wdata[`PBS_PIN_HI:`PBS_PIN_LO]; // [RULE_04]
            end else if (sfr_addr == `PBS_ADDR_SEL) begin
                // no interlock: stopping the units first is up to software
                next_state.sel.tsel = sfr_wdata[`PBS_SEL_TSEL_HI:`PBS_SEL_TSEL_LO]; // [RULE_09] [RULE_10]
                next_state.sel.group = sfr_wdata[`PBS_SEL_GROUP]; // [RULE_08]
                next_state.sel.pair = pbs_pkg::pbs_pair_t'(sfr_wdata[`PBS_SEL_PAIR_HI:`PBS_SEL_PAIR_LO]); // [RULE_07]
            end
        end
        if (sfr_rd) begin
            if (sfr_addr == `PBS_ADDR_LATCH) begin
                next_state.rdata = {state.latch, `PBS_LOW_NIBBLE};
            end else if (sfr_addr == `PBS_ADDR_READBACK) begin
                next_state.rdata = {cell_rd, `PBS_LOW_NIBBLE}; // [RULE_05]
            end else if (sfr_addr == `PBS_ADDR_DIR) begin
                next_state.rdata = {state.dir, `PBS_LOW_NIBBLE};
            end else if (sfr_addr == `PBS_ADDR_FSEL) begin
                next_state.rdata = {1'b0, state.fsel, `PBS_LOW_NIBBLE}; // [RULE_03]
            end else if (sfr_addr == `PBS_ADDR_OTYPE) begin
                next_state.rdata = {state.otype, `PBS_LOW_NIBBLE};
            end else if (sfr_addr == `PBS_ADDR_SEL) begin
                next_state.rdata = {state.sel.tsel, 1'b0, state.sel.group, 2'h0, state.sel.pair};
            end
        end
        next_state.pin_out = cell_out; // [RULE_01]
        next_state.pin_oe = cell_oe; // [RULE_02]
        next_state.unit_en = rt_en; // [RULE_06]
        next_state.periph_in = rt_in;
        next_state.shared_irq = rt_irq; // [RULE_12]
        next_state.port2_out = rt_p2;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= RST_STATE;
        end else begin
            state <= next_state;
        end
    end

    assign sfr_rdata = state.rdata;
    assign pb_pin_out = state.pin_out;
    assign pb_pin_oe = state.pin_oe;
    assign port2_out = state.port2_out;
    assign periph_in = state.periph_in;
    assign shared_irq = state.shared_irq;
    assign unit_en = state.unit_en;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_latch_wr;
        sfr_wr && sfr_addr == `PBS_ADDR_LATCH && state.dir == 4'hf && state.otype == 4'h0 && state.fsel == 3'h0;
    endsequence
    sequence s_quiet;
        !sfr_wr;
    endsequence
    property p_latch_to_pin;
        s_latch_wr ##1 s_quiet |=> pb_pin_out == $past(sfr_wdata[7:4], 2) && pb_pin_oe == 4'hf;
    endproperty
    a_latch_to_pin: assert property (p_latch_to_pin) else $error("latch value not on pins"); // [RULE_01]
    a_input_no_drive: assert property (state.dir == 4'h0 |=> pb_pin_oe == 4'h0) // [RULE_02]
        else $error("input pin driven");
    a_fsel_read: assert property (sfr_rd && sfr_addr == `PBS_ADDR_FSEL |=> sfr_rdata[7] == 1'b0 // [RULE_03]
        && sfr_rdata[6:4] == $past(state.fsel)) else $error("function select readback wrong");
    a_open_drain: assert property (state.otype == 4'hf |=> pb_pin_out == 4'h0) // [RULE_04]
        else $error("open drain drove high");
    a_readback_val: assert property (sfr_rd && sfr_addr == `PBS_ADDR_READBACK |=> sfr_rdata[7:4] == // [RULE_05]
        ($past(pb_pin_in) & ~($past(state.dir) & ~$past(state.otype)))) else $error("pin readback wrong");
    a_two_units: assert property (!(unit_en.uart && unit_en.sio && unit_en.twi)) // [RULE_06]
        else $error("three serial units on");
    a_pair_decode: assert property (state.sel.pair == pbs_pkg::PBS_PAIR_SIO_TWI |=> unit_en == 3'h3) // [RULE_07]
        else $error("pair decode wrong");
    a_group_route: assert property (state.sel.group && state.sel.pair == pbs_pkg::PBS_PAIR_UART_TWI // [RULE_08]
        |=> periph_in.urx == $past(pb_pin_in[1])) else $error("receive not from port b");
    a_timer_src: assert property (state.sel.tsel == `PBS_TSEL_PORT9 // [RULE_09]
        |=> periph_in.timer_in == $past(port9_pin1_in)) else $error("timer input source wrong");
    a_shared_irq: assert property (state.sel.pair == pbs_pkg::PBS_PAIR_UART_SIO // [RULE_12]
        |=> shared_irq[1] == $past(irq.sio)) else $error("shared latch source wrong");
    a_alt_pin6: assert property (state.sel.group && state.sel.pair == pbs_pkg::PBS_PAIR_SIO_TWI // [RULE_13] [RULE_14]
        && state.fsel[2] && state.dir[2] && !state.otype[2] |=> pb_pin_out[2] == $past(periph_out.sclk))
        else $error("pin6 not clock");
endmodule // pbs_port_b

// ===== testbench/pbs_board.sv
`timescale 1ns/1ps
module pbs_board (
    input wire logic [3:0] pb_pin_out,
    input wire logic [3:0] pb_pin_oe,
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    output logic [3:0] pb_pin_in
);
    // released pins take ext_val where ext_en is set, else fall to the pull-up, never hold the last value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pb_pin_in[i] = pb_pin_oe[i] ? pb_pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule // pbs_board

// ===== testbench/pbs_port_b_bench.sv
`timescale 1ns/1ps
module pbs_port_b_bench;
    typedef struct {logic [11:0] addr; logic [7:0] wdata; logic [7:0] exp;} pbs_row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] sfr_addr = 12'h000;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [3:0] pb_pin_in, pb_pin_out, pb_pin_oe;
    logic [3:0] ext_en = 4'h0;
    logic [3:0] ext_val = 4'h0;
    logic p2_in = 1'b0;
    logic p9_in = 1'b0;
    logic [2:0] port2_out;
    logic [1:0] shared_irq;
    pbs_pkg::pbs_periph_out_t periph_out = 3'h0;
    pbs_pkg::pbs_periph_in_t periph_in;
    pbs_pkg::pbs_irq_t irq = 3'h0;
    pbs_pkg::pbs_units_t unit_en;
    int errors = 0;
    int tests_run = 0;
    // {shared_irq, unit_en} per pair code, code 3 first; upper half with only the sio request
    logic [7:0][4:0] pair_exp = {5'h00, 5'h0b, 5'h16, 5'h05, 5'h00, 5'h13, 5'h0e, 5'h1d};
    pbs_row_t rows [7] = '{
        '{12'h00b, 8'hff, 8'hf0}, '{12'hf25, 8'hff, 8'hf0}, '{12'hf3f, 8'hff, 8'h70},
        '{12'hf4c, 8'hff, 8'hf0}, '{12'hfcb, 8'hff, 8'hd3}, '{12'h100, 8'hff, 8'h00},
        '{12'h018, 8'h00, 8'hf0}};

    always #50 ref_clk = ~ref_clk;

    pbs_port_b u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pb_pin_in(pb_pin_in),
        .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe), .port2_pin1_in(p2_in),
        .port9_pin1_in(p9_in), .port2_out(port2_out), .periph_out(periph_out),
        .periph_in(periph_in), .irq(irq), .shared_irq(shared_irq), .unit_en(unit_en));

    pbs_board u_board (.pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pb_pin_in(pb_pin_in));

    task summarize;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        cyc(1);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        cyc(1);
        sfr_wr = 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [7:0] exp);
        cyc(1);
        sfr_addr = a;
        sfr_rd = 1'b1;
        cyc(1);
        sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
    endtask

    task do_reset;
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
        cyc(1);
        chk({4'h0, pb_pin_oe}, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rd_chk(rows[i].addr, 8'h00);
        end
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        summarize();
    end

    initial begin
        do_reset();
        chk({5'h00, unit_en}, 8'h05);
        for (int i = 0; i < 7; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        // second reset in mid-run must clear everything again
        do_reset();
        wr(12'hf25, 8'hf0);
        wr(12'h00b, 8'ha0);
        cyc(2);
        chk({pb_pin_oe, pb_pin_out}, 8'hfa);
        rd_chk(12'h018, 8'h00);
        wr(12'hf4c, 8'hf0);
        cyc(2);
        chk({pb_pin_oe, pb_pin_out}, 8'h50);
        rd_chk(12'h018, 8'ha0);
        wr(12'hf25, 8'h00);
        ext_en = 4'hf;
        ext_val = 4'h6;
        cyc(2);
        rd_chk(12'h018, 8'h60);
        ext_en = 4'h0;
        // selection changes with the irq requests held raised; the units are not stopped first
        for (int p = 0; p < 8; p++) begin
            irq = (p < 4) ? 3'h5 : 3'h2;
            wr(12'hfcb, 8'(p % 4));
            cyc(2);
            chk({3'h0, shared_irq, unit_en}, {3'h0, pair_exp[p]});
        end
        wr(12'hf25, 8'hf0);
        wr(12'hf4c, 8'h00);
        wr(12'h00b, 8'h00);
        wr(12'hf3f, 8'h70);
        periph_out = 3'h6;
        wr(12'hfcb, 8'h12);
        cyc(2);
        chk({1'b0, port2_out, pb_pin_out}, 8'h05);
        wr(12'hfcb, 8'h02);
        cyc(2);
        chk({1'b0, port2_out, pb_pin_out}, 8'h50);
        periph_out = 3'h1;
        wr(12'hfcb, 8'h10);
        cyc(2);
        chk({1'b0, port2_out, pb_pin_out}, 8'h03);
        p2_in = 1'b1;
        wr(12'hfcb, 8'h00);
        cyc(2);
        chk({5'h00, periph_in}, 8'h03);
        wr(12'hfcb, 8'h40);
        cyc(2);
        chk({5'h00, periph_in}, 8'h02);
        p9_in = 1'b1;
        cyc(2);
        chk({5'h00, periph_in}, 8'h03);
        wr(12'hf25, 8'hd0);
        wr(12'hfcb, 8'h12);
        cyc(2);
        chk({5'h00, periph_in}, 8'h07);
        summarize();
    end
endmodule // pbs_port_b_bench
